// file: pch_cmd_reg.sv
`timescale 1ns/1ps
`include "pch_defines.svh"

module pch_cmd_reg (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] cmd_byte,
    output logic mem_en
);

    pch_pkg::pch_cmd_state_t state_reg;
    pch_pkg::pch_cmd_state_t state_next;

    // ----------------------------------------------------------------
    // writable memory response bit
    // ----------------------------------------------------------------
    // only bit 1 stores; every other written bit is dropped here
    always_comb begin
        state_next = state_reg;
        if (wr_en) begin
            state_next.mem_en = wr_data[`PCH_CMD_BIT_MEM]; // [R06] [R10]
        end
    end

    // cleared by reset so local memory stays shut until software opens it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg.mem_en <= `PCH_CMD_MEM_RESET; // [R11]
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // read view: fixed bits are constants, reserved read zero
    // ----------------------------------------------------------------
    always_comb begin
        cmd_byte = `PCH_BYTE_ZERO; // [R03] [R04] [R07] [R10]
        cmd_byte[`PCH_CMD_BIT_MEM] = state_reg.mem_en; // [R06]
        cmd_byte[`PCH_CMD_BIT_MASTER] = `PCH_CMD_MASTER_VALUE; // [R05]
    end

    // enable straight from the flip-flop, no logic behind it
    assign mem_en = state_reg.mem_en;

    a_mem_bit_write: assert property (@(posedge sys_clk) disable iff (rst) // [R06]
        wr_en |=> mem_en == $past(wr_data[`PCH_CMD_BIT_MEM]))
        else $error("memory response bit did not take written value");

    a_mem_bit_hold: assert property (@(posedge sys_clk) disable iff (rst) // [R06]
        !wr_en |=> $stable(mem_en))
        else $error("memory response bit changed without a write");

    a_fixed_bits: assert property (@(posedge sys_clk) disable iff (rst) // [R03] [R04] [R05] [R07]
        cmd_byte[`PCH_CMD_BIT_MASTER] && !cmd_byte[`PCH_CMD_BIT_SPECIAL]
        && !cmd_byte[`PCH_CMD_BIT_PARITY] && !cmd_byte[`PCH_CMD_BIT_IO])
        else $error("fixed command bits wrong");

endmodule

// file: pch_config_header.sv
`timescale 1ns/1ps
`include "pch_defines.svh"

// Functional notes
// R01 - vendor code reads at offsets 00h low and 01h high; writes ignored.
// R02 - part code reads at offsets 02h low and 03h high; writes ignored.
// R03 - parity response bit 6 of command low always reads zero.
// R04 - special cycle enable bit 3 of command low always reads zero.
// R05 - bus master enable bit 2 of command low always reads one.
// R06 - memory response bit 1 writable; gates PCI master access to local memory.
// R07 - I/O response bit 0 reads zero; PCI master I/O never claimed.
// R08 - processor-initiated I/O cycles always answered, regardless of bit 0.
// R09 - claim configuration cycles to device 0 bus 0 with DEVSEL#.
// R10 - reserved bits 7 and 5:4 read zero and ignore writes.
// R11 - memory response bit is zero after reset.

module pch_config_header #(
    parameter logic [15:0] VENDOR_CODE = 16'ha5c3, // arbitrary value
    parameter logic [15:0] PART_CODE = 16'h5a3c // arbitrary value
) (
    input wire logic sys_clk,
    input wire logic rst,
    input pch_pkg::pch_cfg_req_t cfg_req,
    output pch_pkg::pch_cfg_rsp_t cfg_rsp,
    input wire logic pci_mem_req,
    output logic pci_mem_claim,
    input wire logic pci_io_req,
    output logic pci_io_claim,
    input wire logic cpu_io_req,
    output logic cpu_io_claim,
    output logic mem_enable,
    output logic master_enable
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    // all ones is what an empty slot returns, so software would miss us
    if (VENDOR_CODE == 16'hffff) begin : g_bad_vendor
        $error("vendor code must not be all ones");
    end

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    // true when the cycle targets our own bus, device and function
    function automatic logic pch_hit(input pch_pkg::pch_cfg_req_t r);
        pch_hit = r.req && (r.bus == `PCH_OWN_BUS) && (r.dev == `PCH_OWN_DEV)
                  && (r.func == `PCH_OWN_FUNC);
    endfunction

    pch_pkg::pch_main_state_t state_reg;
    pch_pkg::pch_main_state_t state_next;
    logic [7:0] cmd_byte;
    logic cmd_wr;
    logic hit;

    // one decode shared by storage and answer
    assign hit = pch_hit(cfg_req);

    // ----------------------------------------------------------------
    // command low byte storage
    // ----------------------------------------------------------------
    // identity dword has no store, so writes there fall away
    assign cmd_wr = hit && cfg_req.write && (cfg_req.dword == `PCH_DW_COMMAND)
                    && cfg_req.be[`PCH_CMD_LANE]; // [R01] [R02] [R06]

    pch_cmd_reg u_cmd (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(cmd_wr),
        .wr_data(cfg_req.wdata[7:0]),
        .cmd_byte(cmd_byte),
        .mem_en(mem_enable)
    );

    // ----------------------------------------------------------------
    // configuration answer: claim and read data one cycle after request
    // ----------------------------------------------------------------
    // reads return the whole dword; byte enables are left to the host
    always_comb begin
        state_next = state_reg;
        state_next.rsp.ack = hit;
        state_next.rsp.devsel_n = !hit; // [R09]
        state_next.rsp.rdata = `PCH_WORD_ZERO;
        if (hit && !cfg_req.write) begin
            case (cfg_req.dword)
                `PCH_DW_IDENT: begin
                    state_next.rsp.rdata = {PART_CODE, VENDOR_CODE}; // [R01] [R02]
                end
                `PCH_DW_COMMAND: begin
                    // command high and status are not kept here, read zero
                    state_next.rsp.rdata = {24'h00_0000, cmd_byte}; // [R10]
                end
                default: begin
                    state_next.rsp.rdata = `PCH_WORD_ZERO;
                end
            endcase
        end
    end

    // answer register; idle answer is no claim and zero data
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg.rsp.ack <= 1'b0;
            state_reg.rsp.devsel_n <= 1'b1;
            state_reg.rsp.rdata <= `PCH_WORD_ZERO;
        end else begin
            state_reg <= state_next;
        end
    end

    assign cfg_rsp = state_reg.rsp;

    // ----------------------------------------------------------------
    // cycle claims
    // ----------------------------------------------------------------
    assign pci_mem_claim = pci_mem_req && mem_enable; // [R06]
    assign pci_io_claim = 1'b0; // [R07]
    assign cpu_io_claim = cpu_io_req; // [R08]
    assign master_enable = cmd_byte[`PCH_CMD_BIT_MASTER]; // [R05]

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_claim_own_slot: assert property (@(posedge sys_clk) disable iff (rst) // [R09]
        pch_hit(cfg_req) |=> !cfg_rsp.devsel_n && cfg_rsp.ack)
        else $error("own configuration cycle not claimed");

    a_no_foreign_claim: assert property (@(posedge sys_clk) disable iff (rst) // [R09]
        !pch_hit(cfg_req) |=> cfg_rsp.devsel_n && !cfg_rsp.ack)
        else $error("foreign configuration cycle claimed");

    a_ident_read: assert property (@(posedge sys_clk) disable iff (rst) // [R01] [R02]
        pch_hit(cfg_req) && !cfg_req.write && cfg_req.dword == `PCH_DW_IDENT
        |=> cfg_rsp.rdata == {PART_CODE, VENDOR_CODE})
        else $error("identity dword read wrong");

    a_cmd_read: assert property (@(posedge sys_clk) disable iff (rst) // [R03] [R04] [R05] [R06]
        pch_hit(cfg_req) && !cfg_req.write && cfg_req.dword == `PCH_DW_COMMAND
        |=> cfg_rsp.rdata[7:0] == {5'h00, $past(mem_enable) ? 3'h6 : 3'h4}
        && cfg_rsp.rdata[31:8] == 24'h00_0000)
        else $error("command low byte read wrong");

    a_mem_write_through: assert property (@(posedge sys_clk) disable iff (rst) // [R06]
        pch_hit(cfg_req) && cfg_req.write && cfg_req.dword == `PCH_DW_COMMAND
        && cfg_req.be[`PCH_CMD_LANE]
        |=> mem_enable == $past(cfg_req.wdata[`PCH_CMD_BIT_MEM]))
        else $error("command write did not reach memory response bit");

    a_ident_write_void: assert property (@(posedge sys_clk) disable iff (rst) // [R01] [R02]
        pch_hit(cfg_req) && cfg_req.write && cfg_req.dword == `PCH_DW_IDENT
        |=> $stable(mem_enable))
        else $error("write to identity dword changed state");

    a_mem_gate: assert property (@(posedge sys_clk) disable iff (rst) // [R06]
        pci_mem_claim == (pci_mem_req && mem_enable))
        else $error("local memory claim not gated by enable");

    a_io_claims: assert property (@(posedge sys_clk) disable iff (rst) // [R07] [R08]
        !pci_io_claim && (cpu_io_claim == cpu_io_req))
        else $error("I/O claim wrong");

    a_reset_mem_off: assert property (@(posedge sys_clk) // [R11]
        $fell(rst) |-> !mem_enable)
        else $error("memory response bit not cleared by reset");

endmodule

// file: pch_defines.svh
`ifndef PCH_DEFINES_SVH
`define PCH_DEFINES_SVH

// ----------------------------------------------------------------
// configuration space map (byte offsets and dword indices)
// ----------------------------------------------------------------
`define PCH_OFS_VENDOR_LO 8'h00
`define PCH_OFS_VENDOR_HI 8'h01
`define PCH_OFS_PART_LO 8'h02
`define PCH_OFS_PART_HI 8'h03
`define PCH_OFS_COMMAND_LO 8'h04
`define PCH_DW_IDENT 6'h00
`define PCH_DW_COMMAND 6'h01

// ----------------------------------------------------------------
// own bus, device and function numbers
// ----------------------------------------------------------------
`define PCH_OWN_BUS 8'h00
`define PCH_OWN_DEV 5'h00
`define PCH_OWN_FUNC 3'h0

// ----------------------------------------------------------------
// command low byte fields
// ----------------------------------------------------------------
`define PCH_CMD_BIT_IO 0
`define PCH_CMD_BIT_MEM 1
`define PCH_CMD_BIT_MASTER 2
`define PCH_CMD_BIT_SPECIAL 3
`define PCH_CMD_BIT_PARITY 6
`define PCH_CMD_LANE 0
`define PCH_CMD_MEM_RESET 1'b0
`define PCH_CMD_MASTER_VALUE 1'b1
`define PCH_BYTE_ZERO 8'h00
`define PCH_WORD_ZERO 32'h0000_0000

`endif

// file: pch_host_model.sv
`timescale 1ns/1ps
module pch_host_model (
    input wire logic sys_clk,
    output pch_pkg::pch_cfg_req_t cfg_req,
    input pch_pkg::pch_cfg_rsp_t cfg_rsp
);
    // ----
    // host side
    // ----
    // idle fields carry junk so a stale value can never pass for a fresh one
    initial begin
        cfg_req = '0;
        cfg_req.wdata = 32'h5a5a_a5a5;
    end

    // one cycle: request for one edge, answer looked at one cycle later
    task automatic access(input logic wr, input logic [15:0] tgt, input logic [5:0] dw,
                          input logic [3:0] be, input logic [31:0] wd,
                          output logic ack, output logic dsel_n, output logic [31:0] rd);
        @(negedge sys_clk);
        cfg_req.req = 1'b1;
        cfg_req.write = wr;
        {cfg_req.bus, cfg_req.dev, cfg_req.func} = tgt;
        cfg_req.dword = dw;
        cfg_req.be = be;
        cfg_req.wdata = wd;
        @(negedge sys_clk);
        ack = cfg_rsp.ack;
        dsel_n = cfg_rsp.devsel_n;
        rd = cfg_rsp.rdata;
        cfg_req.req = 1'b0;
        cfg_req.wdata = ~wd;
        cfg_req.dword = ~dw;
        cfg_req.be = ~be;
    endtask
endmodule

// file: pch_pkg.sv
package pch_pkg;

    // configuration cycle request, one cycle wide
    typedef struct packed {
        logic req;
        logic write;
        logic [7:0] bus;
        logic [4:0] dev;
        logic [2:0] func;
        logic [5:0] dword;
        logic [3:0] be;
        logic [31:0] wdata;
    } pch_cfg_req_t;

    // configuration cycle answer, all from flip-flops
    typedef struct packed {
        logic ack;
        logic devsel_n;
        logic [31:0] rdata;
    } pch_cfg_rsp_t;

    typedef struct packed {
        pch_cfg_rsp_t rsp;
    } pch_main_state_t;

    typedef struct packed {
        logic mem_en;
    } pch_cmd_state_t;

endpackage

// file: tb.sv
`timescale 1ns/1ps
module tb;
    localparam logic [15:0] VEND = 16'h1b2d; // arbitrary value
    localparam logic [15:0] PART = 16'h7e41; // arbitrary value
    // foreign targets {bus, dev, func}: bus 1, device 1, function 1
    localparam logic [47:0] FOREIGN = {16'h0100, 16'h0008, 16'h0001};
    logic sys_clk, rst, pci_mem_req, pci_io_req, cpu_io_req;
    logic pci_mem_claim, pci_io_claim, cpu_io_claim, mem_enable, master_enable;
    pch_pkg::pch_cfg_req_t cfg_req;
    pch_pkg::pch_cfg_rsp_t cfg_rsp;
    int fails, n_checks;
    logic ack, dsel_n;
    logic [31:0] rd;

    pch_config_header #(.VENDOR_CODE(VEND), .PART_CODE(PART)) dut (
        .sys_clk(sys_clk), .rst(rst), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
        .pci_mem_req(pci_mem_req), .pci_mem_claim(pci_mem_claim),
        .pci_io_req(pci_io_req), .pci_io_claim(pci_io_claim),
        .cpu_io_req(cpu_io_req), .cpu_io_claim(cpu_io_claim),
        .mem_enable(mem_enable), .master_enable(master_enable));
    pch_host_model host (.sys_clk(sys_clk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));

    // ----
    // clock and helpers
    // ----
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // own target only; a claimed cycle must ack with devsel low
    task automatic rd_chk(input string name, input logic [5:0] dw, input logic [31:0] exp);
        host.access(1'b0, 16'h0000, dw, 4'hf, 32'h0, ack, dsel_n, rd);
        chk({name, " claim"}, {30'h0, ack, dsel_n}, 32'h2);
        chk(name, rd, exp);
    endtask

    task automatic wr(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] wd);
        host.access(1'b1, 16'h0000, dw, be, wd, ack, dsel_n, rd);
        chk("write claim", {30'h0, ack, dsel_n}, 32'h2);
    endtask

    // ----
    // tests
    // ----
    initial begin
        rst = 1'b1;
        pci_mem_req = 1'b0;
        pci_io_req = 1'b0;
        cpu_io_req = 1'b0;
        fails = 0;
        n_checks = 0;
        repeat (16) @(negedge sys_clk);
        chk("master in reset", {31'h0, master_enable}, 32'h1);
        chk("cpu io idle", {31'h0, cpu_io_claim}, 32'h0);
        rst = 1'b0;
        chk("mem after reset", {31'h0, mem_enable}, 32'h0);
        rd_chk("id dword", 6'h00, {PART, VEND});
        rd_chk("cmd idle", 6'h01, 32'h0000_0004);
        wr(6'h00, 4'hf, 32'hffff_ffff);
        rd_chk("id after write", 6'h00, {PART, VEND});
        wr(6'h01, 4'he, 32'h0000_00ff);
        rd_chk("cmd lane off", 6'h01, 32'h0000_0004);
        wr(6'h01, 4'h1, 32'h0000_00ff);
        rd_chk("cmd all ones", 6'h01, 32'h0000_0006);
        pci_mem_req = 1'b1;
        pci_io_req = 1'b1;
        cpu_io_req = 1'b1;
        #1;
        chk("mem claim on", {31'h0, pci_mem_claim}, 32'h1);
        chk("pci io claim", {31'h0, pci_io_claim}, 32'h0);
        chk("cpu io claim", {31'h0, cpu_io_claim}, 32'h1);
        wr(6'h01, 4'h1, 32'h0000_00fd);
        #1;
        chk("mem claim off", {31'h0, pci_mem_claim}, 32'h0);
        chk("cpu io claim off", {31'h0, cpu_io_claim}, 32'h1);
        // foreign bus, device or function: no claim and no effect
        for (int i = 0; i < 3; i++) begin
            host.access(1'b1, FOREIGN[i*16 +: 16], 6'h01, 4'h1,
                        32'h0000_00ff, ack, dsel_n, rd);
            chk("foreign claim", {30'h0, ack, dsel_n}, 32'h1);
        end
        rd_chk("cmd after foreign", 6'h01, 32'h0000_0004);
        // reset in mid-run must drop the memory bit again
        wr(6'h01, 4'h1, 32'h0000_0002);
        chk("mem before reset", {31'h0, mem_enable}, 32'h1);
        rst = 1'b1;
        #1;
        chk("mem in reset", {31'h0, mem_enable}, 32'h0);
        @(negedge sys_clk);
        rst = 1'b0;
        rd_chk("cmd after reset", 6'h01, 32'h0000_0004);
        close_out();
    end

    // watchdog: the tests need well under 200 cycles
    initial begin
        repeat (2000) @(posedge sys_clk);
        fails++;
        close_out();
    end
endmodule
